/* File: hdl/wdc_defs.svh */
`ifndef WDC_DEFS_SVH
`define WDC_DEFS_SVH

// Register byte offsets
`define WDC_ADR_CTRL   8'h00
`define WDC_ADR_MODE   8'h04
`define WDC_ADR_STAT   8'h08
`define WDC_ADR_EVT    8'h0c
`define WDC_ADR_SRST   8'h10

// Locked control register fields
`define WDC_CTL_EI     0
`define WDC_CTL_LCK    1
`define WDC_CTL_IS     2
`define WDC_CTL_DR     3
`define WDC_CTL_GLO    4
`define WDC_CTL_GHI    7
`define WDC_CTL_PWLO   8
`define WDC_CTL_PWHI   15
`define WDC_CTL_RLLO   16
`define WDC_CTL_RLHI   31
`define WDC_GUARD      4'hf

// Mode request register fields
`define WDC_MOD_IR     2
`define WDC_MOD_DR     3

// Status register fields
`define WDC_ST_AE      0
`define WDC_ST_OE      1
`define WDC_ST_IS      2
`define WDC_ST_DS      3
`define WDC_ST_TO      4
`define WDC_ST_PR      5
`define WDC_ST_CNTLO   16

// Event register fields
`define WDC_EV_NMI     0
`define WDC_EV_RST     1
`define WDC_EV_DBL     2

// Reset values and counter marks
`define WDC_RST_RELOAD 16'h0000
`define WDC_RST_PW     8'h00
`define WDC_CNT_START  16'hfffc
`define WDC_CNT_MAX    16'hffff
`define WDC_CNT_WAKE   16'h7fff
`define WDC_DIV_FAST   256
`define WDC_DIV_SLOW   16384
`define WDC_CAP_EDGES  2'h3

`endif

/* File: hdl/wdc_pkg.sv */
package wdc_pkg;

	typedef enum logic [3:0] {
		WDC_TIMEOUT  = 4'b0001,
		WDC_NORMAL   = 4'b0010,
		WDC_DISABLED = 4'b0100,
		WDC_PREWARN  = 4'b1000
	} wdc_mode_type;

	typedef struct packed {
		logic ae;
		logic oe;
		logic is;
		logic ds;
		logic to;
		logic pr;
	} wdc_flags_type;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wdc_wb_req_type;

endpackage

/* File: hdl/wdc_clk_div.sv */
`timescale 1ns/1ps
`include "wdc_defs.svh"

module wdc_clk_div #(
	parameter int DIV_FAST = `WDC_DIV_FAST,
	parameter int DIV_SLOW = `WDC_DIV_SLOW
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Rate select and tick
	input  wire logic fastSel,
	output logic      tick
);
	localparam int SW = $clog2(DIV_SLOW);
	localparam int FW = $clog2(DIV_FAST);

	logic [SW-1:0] div_q;
	logic          tick_q;

	// Free running: not aligned to mode changes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + SW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= fastSel ? (&div_q[FW-1:0]) : (&div_q);
		end
	end

	assign tick = tick_q;

	a_tick_spacing : assert property (@(posedge clk) disable iff (!rst_n)
		tick_q |=> !tick_q)
		else $error("divider tick on two adjacent cycles");

endmodule

/* File: hdl/wdc_watchdog_ctrl.sv */
`timescale 1ns/1ps
`include "wdc_defs.svh"
// Function
// - Disabled state only from time-out mode, init-end set with disable request
// - Disabled entry clears error, prewarn, time-out flags; sets disabled; freezes count
// - Disabled: valid password goes to time-out; bad access errors to prewarning
// - Prewarning entered on overflow or control access error outside prewarning
// - Prewarning entry sets the watchdog NMI flag, raising an NMI
// - Prewarning entry loads FFFC, sets prewarn flag, clears disabled, keeps divider
// - Time-out flag kept on prewarning entry
// - Prewarning ignores control accesses for mode; bad ones still set access error
// - Mode-request writes in prewarning are rejected with a bus error
// - Prewarning overflow FFFF to 0000 requests system reset, sets reset flag
// - Soft reset clears error flags; watchdog reset does not
// - CPU idle, not disabled: count 7FFF to 8000 sets NMI flag
// - Wake-up NMI is no error; mode stays, overflow still leads to prewarning
// - Debug enabled at reset: count halts during debug suspend
// - Watchdog reset keeps access and overflow error flags
// - New error with error flag set: after prewarning hold chip in reset
// - Count ticks at system clock divided by 256 or 16384
// - Correct password clears lock for exactly one modify access

module wdc_watchdog_ctrl
	import wdc_pkg::*;
#(
	parameter int DIV_FAST = `WDC_DIV_FAST,
	parameter int DIV_SLOW = `WDC_DIV_SLOW
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           rst_n,
	// Wishbone slave
	input  wire wdc_wb_req_type wbReq,
	output logic                wbAck,
	output logic                wbErr,
	output logic [31:0]         wbDatOut,
	// System status inputs
	input  wire logic           cpuIdle,
	input  wire logic           debugEnablePin,
	input  wire logic           debugSuspend,
	// Requests to the system
	output logic                nmiReq,
	output logic                sysRstReq,
	output logic                rstHold
);
	wdc_mode_type  mode_q;
	wdc_flags_type flags_q;
	logic [15:0]   count_q;
	logic [15:0]   reload_q;
	logic [7:0]    pw_q;
	logic          lock_q, init_end_lock_q, dr_q, ir_q;
	logic          ack_q, err_q;
	logic [31:0]   dat_q;
	logic          nmiFlag_q, rstFlag_q, dblErr_q, rstHold_q, sysRst_q;
	logic          enMeta_q, enSync_q, suspMeta_q, suspSync_q;
	logic          dbgEn_q;
	logic [1:0]    capCnt_q;
	logic          tick;

	wdc_clk_div #(
		.DIV_FAST (DIV_FAST),
		.DIV_SLOW (DIV_SLOW)
	) u_div (
		.clk     (clk),
		.rst_n   (rst_n),
		.fastSel (flags_q.is),
		.tick    (tick)
	);

	function automatic logic adrIs(input logic [7:0] a,
		input logic [7:0] r);
		adrIs = (a == r);
	endfunction

	// Bus decode
	logic        busNew, ctrlWr, modeWr, swRst;
	logic [31:0] wd;
	assign busNew = wbReq.cyc & wbReq.stb & ~ack_q & ~err_q;
	assign wd     = wbReq.dat;
	assign ctrlWr = busNew & wbReq.we & adrIs(wbReq.adr, `WDC_ADR_CTRL);
	assign modeWr = busNew & wbReq.we & adrIs(wbReq.adr, `WDC_ADR_MODE);
	assign swRst  = busNew & wbReq.we & adrIs(wbReq.adr, `WDC_ADR_SRST)
		& wbReq.sel[0] & wd[0];

	// Access classification
	logic pwVal, modVal, pwOk, modOk, accErr;
	assign pwVal = (wd[`WDC_CTL_RLHI:`WDC_CTL_RLLO] == reload_q)
		& (wd[`WDC_CTL_PWHI:`WDC_CTL_PWLO] == pw_q)
		& (wd[`WDC_CTL_GHI:`WDC_CTL_GLO] == `WDC_GUARD)
		& (wd[`WDC_CTL_DR] == dr_q) & (wd[`WDC_CTL_IS] == flags_q.is)
		& ~wd[`WDC_CTL_LCK] & (wd[`WDC_CTL_EI] == init_end_lock_q);
	assign modVal = (wd[`WDC_CTL_GHI:`WDC_CTL_GLO] == `WDC_GUARD)
		& ~wd[`WDC_CTL_DR] & ~wd[`WDC_CTL_IS] & wd[`WDC_CTL_LCK];
	assign pwOk   = ctrlWr & lock_q & pwVal & (&wbReq.sel);
	assign modOk  = ctrlWr & ~lock_q & modVal & (&wbReq.sel);
	assign accErr = ctrlWr & ~(pwOk | modOk);

	// Mode events
	logic isTo, isNorm, isDis, isPre, run, ovf, wdRst, warm, wake;
	logic exitTo, enterDis, enterNorm, enterTo, enterPre;
	assign isTo   = (mode_q == WDC_TIMEOUT);
	assign isNorm = (mode_q == WDC_NORMAL);
	assign isDis  = (mode_q == WDC_DISABLED);
	assign isPre  = (mode_q == WDC_PREWARN);
	assign run    = ~isDis & ~(dbgEn_q & suspSync_q) & ~rstHold_q;
	assign ovf    = (isTo | isNorm) & run & tick
		& (count_q == `WDC_CNT_MAX);
	assign wdRst  = isPre & run & tick & (count_q == `WDC_CNT_MAX);
	assign warm   = wdRst | swRst;
	assign wake   = cpuIdle & ~isDis & run & tick
		& (count_q == `WDC_CNT_WAKE);
	assign exitTo    = modOk & isTo & wd[`WDC_CTL_EI];
	assign enterDis  = exitTo & dr_q;
	assign enterNorm = exitTo & ~dr_q;
	assign enterTo   = pwOk & (isNorm | isDis);
	assign enterPre  = (accErr & ~isPre) | ovf;

	// Level inputs from pins, two stages each
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enMeta_q   <= 1'b0;
			enSync_q   <= 1'b0;
			suspMeta_q <= 1'b0;
			suspSync_q <= 1'b0;
		end else begin
			enMeta_q   <= debugEnablePin;
			enSync_q   <= enMeta_q;
			suspMeta_q <= debugSuspend;
			suspSync_q <= suspMeta_q;
		end
	end

	// Debug enable caught once the synchroniser has settled after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capCnt_q <= 2'h0;
			dbgEn_q  <= 1'b0;
		end else if (capCnt_q != `WDC_CAP_EDGES) begin
			capCnt_q <= capCnt_q + 2'h1;
			dbgEn_q  <= enSync_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= WDC_TIMEOUT;
		end else if (warm) begin
			mode_q <= WDC_TIMEOUT;
		end else if (enterPre) begin
			mode_q <= WDC_PREWARN;
		end else if (enterTo) begin
			mode_q <= WDC_TIMEOUT;
		end else if (enterDis) begin
			mode_q <= WDC_DISABLED;
		end else if (enterNorm) begin
			mode_q <= WDC_NORMAL;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= `WDC_CNT_START;
		end else if (warm | enterPre | enterTo) begin
			count_q <= `WDC_CNT_START;
		end else if (enterNorm) begin
			count_q <= wd[`WDC_CTL_RLHI:`WDC_CTL_RLLO];
		end else if (enterDis) begin
			count_q <= count_q;
		end else if (run & tick) begin
			count_q <= count_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q    <= '0;
			flags_q.to <= 1'b1;
		end else if (swRst) begin
			flags_q    <= '0;
			flags_q.to <= 1'b1;
		end else if (wdRst) begin
			flags_q.is <= 1'b0;
			flags_q.ds <= 1'b0;
			flags_q.pr <= 1'b0;
			flags_q.to <= 1'b1;
		end else if (enterPre) begin
			flags_q.pr <= 1'b1;
			flags_q.ds <= 1'b0;
			flags_q.ae <= flags_q.ae | accErr;
			flags_q.oe <= flags_q.oe | ovf;
		end else if (enterTo) begin
			flags_q.to <= 1'b1;
			flags_q.ds <= 1'b0;
		end else if (exitTo) begin
			flags_q    <= '0;
			flags_q.ds <= dr_q;
			flags_q.is <= ir_q;
		end else if (accErr) begin
			flags_q.ae <= 1'b1;
		end
	end

	// Locked control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_q    <= 1'b1;
			init_end_lock_q <= 1'b0;
			pw_q      <= `WDC_RST_PW;
			reload_q  <= `WDC_RST_RELOAD;
		end else if (warm) begin
			lock_q    <= 1'b1;
			init_end_lock_q <= 1'b0;
			pw_q      <= `WDC_RST_PW;
			reload_q  <= `WDC_RST_RELOAD;
		end else if (pwOk) begin
			lock_q <= 1'b0;
		end else if (ctrlWr & ~lock_q) begin
			lock_q <= 1'b1;
			if (modOk) begin
				init_end_lock_q <= wd[`WDC_CTL_EI];
				pw_q      <= wd[`WDC_CTL_PWHI:`WDC_CTL_PWLO];
				reload_q  <= wd[`WDC_CTL_RLHI:`WDC_CTL_RLLO];
			end
		end
	end

	// Mode request register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dr_q <= 1'b0;
			ir_q <= 1'b0;
		end else if (warm) begin
			dr_q <= 1'b0;
			ir_q <= 1'b0;
		end else if (modeWr & wbReq.sel[0] & ~init_end_lock_q & ~isPre) begin
			dr_q <= wd[`WDC_MOD_DR];
			ir_q <= wd[`WDC_MOD_IR];
		end
	end

	// Event flags; a set in the clearing cycle wins
	logic evtW1c;
	assign evtW1c = busNew & wbReq.we & wbReq.sel[0]
		& adrIs(wbReq.adr, `WDC_ADR_EVT);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmiFlag_q <= 1'b0;
			rstFlag_q <= 1'b0;
		end else begin
			nmiFlag_q <= (enterPre | wake)
				| (nmiFlag_q & ~(evtW1c & wd[`WDC_EV_NMI]));
			rstFlag_q <= wdRst
				| (rstFlag_q & ~(evtW1c & wd[`WDC_EV_RST]));
		end
	end

	// Double error detection and reset requests
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dblErr_q  <= 1'b0;
			rstHold_q <= 1'b0;
			sysRst_q  <= 1'b0;
		end else begin
			sysRst_q <= wdRst;
			if (swRst) begin
				dblErr_q <= 1'b0;
			end else if (enterPre & (flags_q.ae | flags_q.oe)) begin
				dblErr_q <= 1'b1;
			end
			if (wdRst & dblErr_q) begin
				rstHold_q <= 1'b1;
			end
		end
	end

	// Bus answer: one cycle after the request
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		case (wbReq.adr)
			`WDC_ADR_CTRL: rdMux = {reload_q, pw_q, 4'h0, dr_q,
				flags_q.is, lock_q, init_end_lock_q};
			`WDC_ADR_MODE: rdMux = {28'h0, dr_q, ir_q, 2'h0};
			`WDC_ADR_STAT: rdMux = {count_q, 10'h0, flags_q.pr, flags_q.to,
				flags_q.ds, flags_q.is, flags_q.oe, flags_q.ae};
			`WDC_ADR_EVT:  rdMux = {29'h0, dblErr_q, rstFlag_q, nmiFlag_q};
			default:       rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= busNew & ~(modeWr & isPre);
			err_q <= modeWr & isPre;
			dat_q <= (busNew & ~wbReq.we) ? rdMux : 32'h0000_0000;
		end
	end

	assign wbAck     = ack_q;
	assign wbErr     = err_q;
	assign wbDatOut  = dat_q;
	assign nmiReq    = nmiFlag_q;
	assign sysRstReq = sysRst_q;
	assign rstHold   = rstHold_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_dis_entry : assert property (enterDis & ~warm & ~enterPre |=>
		isDis
		&& flags_q.ds && !flags_q.ae && !flags_q.oe && !flags_q.pr
		&& !flags_q.to && count_q == $past(count_q))
		else $error("disabled entry wrong");
	a_dis_frozen : assert property (isDis && $past(isDis)
		|-> count_q == $past(count_q))
		else $error("count moved while disabled");
	a_pre_entry : assert property (enterPre & ~warm |=> isPre
		&& count_q == `WDC_CNT_START && flags_q.pr && !flags_q.ds
		&& nmiFlag_q)
		else $error("prewarning entry wrong");
	a_pre_keep : assert property (enterPre & ~warm |=>
		flags_q.to == $past(flags_q.to) && flags_q.is == $past(flags_q.is))
		else $error("prewarning changed time-out or divider flag");
	a_pre_stay : assert property (isPre && !warm |=> isPre)
		else $error("prewarning left without reset");
	a_pre_modewr : assert property (modeWr && isPre && !warm |=> wbErr
		&& !wbAck
		&& dr_q == $past(dr_q) && ir_q == $past(ir_q))
		else $error("mode write in prewarning not refused");
	a_pre_reset : assert property (wdRst |=> sysRstReq && rstFlag_q
		&& isTo ##1 !sysRstReq)
		else $error("prewarning overflow did not reset");
	a_soft_clear : assert property (swRst |=> !flags_q.ae
		&& !flags_q.oe && !dblErr_q)
		else $error("soft reset kept error flags");
	a_wake_nmi : assert property (wake && !warm && !enterPre
		&& !enterTo && !exitTo |=>
		nmiFlag_q && mode_q == $past(mode_q))
		else $error("wake-up NMI missing or mode changed");
	a_wd_keeperr : assert property (wdRst && !swRst |=> flags_q.ae
		== $past(flags_q.ae) && flags_q.oe == $past(flags_q.oe))
		else $error("watchdog reset cleared error flags");
	a_dbl_hold : assert property (wdRst && dblErr_q |=> rstHold[*8])
		else $error("double error did not hold reset");
	a_susp_halt : assert property (dbgEn_q && suspSync_q && !warm
		&& !enterPre && !enterTo && !enterNorm |=> count_q == $past(count_q))
		else $error("count moved during debug suspend");
	a_pw_unlock : assert property (pwOk && !warm |=> !lock_q)
		else $error("password did not open the lock");
	a_pw_relock : assert property (ctrlWr && !lock_q && !warm
		|=> lock_q)
		else $error("lock stayed open after a modify access");

	c_dis_entry  : cover property (enterDis);
	c_pre_access : cover property (accErr && isNorm);
	c_wd_reset   : cover property (wdRst);
	c_wake_nmi   : cover property (wake && isNorm);

endmodule

/* File: verification/wdc_sys_model.sv */
`timescale 1ns/1ps

module wdc_sys_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Requests from the watchdog
	input  wire logic       nmiReq,
	input  wire logic       sysRstReq,
	// Observed counts
	output logic      [7:0] rstCount,
	output logic      [7:0] nmiCount
);
	logic nmiSeen_q;

	// Counts reset pulses and rising edges of the NMI request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstCount  <= 8'h00;
			nmiCount  <= 8'h00;
			nmiSeen_q <= 1'b0;
		end else begin
			nmiSeen_q <= nmiReq;
			if (sysRstReq)
				rstCount <= rstCount + 8'h01;
			if (nmiReq && !nmiSeen_q)
				nmiCount <= nmiCount + 8'h01;
		end
	end
endmodule

/* File: verification/tb_wdc_watchdog_ctrl.sv */
`timescale 1ns/1ps
`include "wdc_defs.svh"

module tb_wdc_watchdog_ctrl
	import wdc_pkg::*;
;
	localparam int FAST  = 4;
	localparam int SLOW  = 16;
	localparam int LIMIT = 5000;

	logic           clk;
	logic           rst_n;
	wdc_wb_req_type req;
	logic           ack;
	logic           err;
	logic [31:0]    rdat;
	logic           cpuIdle;
	logic           dbgEn;
	logic           dbgSus;
	logic           nmiReq;
	logic           sysRstReq;
	logic           rstHold;
	logic [7:0]     rstCount;
	logic [7:0]     nmiCount;
	int             fail_count = 0;
	int             cmp_count  = 0;
	int             cycles     = 0;

	wdc_watchdog_ctrl #(.DIV_FAST(FAST), .DIV_SLOW(SLOW)) u_wdc_watchdog_ctrl (
		.clk(clk), .rst_n(rst_n), .wbReq(req), .wbAck(ack), .wbErr(err),
		.wbDatOut(rdat), .cpuIdle(cpuIdle), .debugEnablePin(dbgEn),
		.debugSuspend(dbgSus), .nmiReq(nmiReq), .sysRstReq(sysRstReq),
		.rstHold(rstHold));

	wdc_sys_model u_wdc_sys_model (
		.clk(clk), .rst_n(rst_n), .nmiReq(nmiReq), .sysRstReq(sysRstReq),
		.rstCount(rstCount), .nmiCount(nmiCount));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; request held until ack or err is sampled
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		req <= wdc_wb_req_type'{1'b1, 1'b1, w, a, 4'hf, d};
		do begin
			@(posedge clk);
			n++;
		end while (!(ack === 1'b1 || err === 1'b1) && n < 20);
		r = rdat;
		e = err;
		req <= '0;
		chk("bus answer", 32'h1, {31'h0, n < 20});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		bus(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		bus(1'b0, a, 32'h0, r, e);
	endtask

	task automatic doReset();
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	// Waits for the reset (s=0) or NMI (s=1) count to reach a target
	task automatic waitFor(input logic s, input logic [7:0] target);
		int n;
		n = 0;
		while ((s ? nmiCount : rstCount) !== target && n < 400) begin
			@(posedge clk);
			n++;
		end
		chk("event count", {24'h0, target}, {24'h0, s ? nmiCount : rstCount});
	endtask

	// Ticks seen over exactly 40 fast periods between two sampling edges
	task automatic rate(output logic [31:0] d);
		logic [31:0] a;
		logic [31:0] b;
		rd(`WDC_ADR_STAT, a);
		repeat (40 * FAST - 3) @(posedge clk);
		rd(`WDC_ADR_STAT, b);
		d = {16'h0, b[31:16] - a[31:16]};
	endtask

	task automatic testDisable();
		logic [31:0] r;
		logic [31:0] c;
		logic        e;
		wr(`WDC_ADR_MODE, 32'h0000_0008);
		wr(`WDC_ADR_CTRL, 32'h0000_00f8);
		rd(`WDC_ADR_CTRL, r);
		chk("lock bit", 32'h0, {31'h0, r[1]});
		wr(`WDC_ADR_CTRL, 32'h0000_00f3);
		rd(`WDC_ADR_STAT, c);
		chk("disabled flags", 32'h08, {26'h0, c[5:0]});
		repeat (3 * SLOW) @(posedge clk);
		rd(`WDC_ADR_STAT, r);
		chk("frozen count", {16'h0, c[31:16]}, {16'h0, r[31:16]});
		wr(`WDC_ADR_CTRL, 32'h0);
		wr(`WDC_ADR_CTRL, 32'h0000_00f9);
		rd(`WDC_ADR_STAT, r);
		chk("prewarn flags", 32'h21, {26'h0, r[5:0]});
		chk("prewarn count", 32'h3fff, {18'h0, r[31:18]});
		chk("nmi request", 32'h1, {31'h0, nmiReq});
		bus(1'b1, `WDC_ADR_MODE, 32'h4, r, e);
		chk("mode write error", 32'h1, {31'h0, e});
		waitFor(1'b0, 8'h01);
		rd(`WDC_ADR_STAT, r);
		chk("kept errors", 32'h11, {26'h0, r[5:0]});
		rd(`WDC_ADR_EVT, r);
		chk("event flags", 32'h3, {29'h0, r[2:0]});
		waitFor(1'b0, 8'h02);
		repeat (200) @(posedge clk);
		chk("reset hold", 32'h1, {31'h0, rstHold});
		chk("no more resets", 32'h2, {24'h0, rstCount});
		$display("test disable_prewarn done");
	endtask

	task automatic testSoft();
		logic [31:0] r;
		wr(`WDC_ADR_CTRL, 32'h0);
		wr(`WDC_ADR_SRST, 32'h1);
		rd(`WDC_ADR_STAT, r);
		chk("soft reset flags", 32'h10, {26'h0, r[5:0]});
		$display("test soft_reset done");
	endtask

	task automatic testWake();
		logic [31:0] r;
		cpuIdle <= 1'b1;
		wr(`WDC_ADR_MODE, 32'h0000_0004);
		wr(`WDC_ADR_CTRL, 32'h0000_00f0);
		wr(`WDC_ADR_CTRL, 32'h7ffe_00f3);
		waitFor(1'b1, 8'h01);
		rd(`WDC_ADR_STAT, r);
		chk("wake flags", 32'h04, {26'h0, r[5:0]});
		rate(r);
		chk("tick rate", 32'd40, r);
		dbgSus <= 1'b1;
		repeat (4) @(posedge clk);
		rate(r);
		chk("suspended rate", 32'd0, r);
		dbgSus <= 1'b0;
		repeat (4) @(posedge clk);
		rate(r);
		chk("resumed rate", 32'd40, r);
		$display("test wake_debug done");
	endtask

	initial begin
		rst_n   = 1'b0;
		req     = '0;
		cpuIdle = 1'b0;
		dbgEn   = 1'b1;
		dbgSus  = 1'b0;
		doReset();
		testDisable();
		doReset();
		testSoft();
		doReset();
		testWake();
		summarize();
	end
endmodule
